//--- djkff_pkg.sv
/*
 * Constants shared by the dual steered flip-flop block: stage count,
 * reset levels and the encoding of the sampled steering pair.
 * Assumes a single 40 MHz system clock and synchronous pin inputs.
 */
package djkff_pkg;

	// ------------------------------------------------------------
	// structure
	// ------------------------------------------------------------
	localparam int DJKFF_NUM_STAGES = 2;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic DJKFF_Q_RST = 1'h0;
	localparam logic DJKFF_QN_RST = 1'h1;
	localparam logic DJKFF_PIN_RST = 1'h0;

	// ------------------------------------------------------------
	// steering pair {set_steer, reset_steer_n}
	// ------------------------------------------------------------
	localparam logic [1:0] DJKFF_STEER_LOAD0 = 2'h0;
	localparam logic [1:0] DJKFF_STEER_HOLD = 2'h1;
	localparam logic [1:0] DJKFF_STEER_TOGGLE = 2'h2;
	localparam logic [1:0] DJKFF_STEER_LOAD1 = 2'h3;

endpackage

//--- djkff_edge.sv
/*
 * Rising-edge finder for the per-stage clock pins.
 * Assumes the pins are synchronous to clk, so no synchroniser is needed.
 */
`timescale 1ns/1ps
module djkff_edge
#(
	parameter int W = djkff_pkg::DJKFF_NUM_STAGES
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [W-1:0] pin,
	output logic [W-1:0] rise
);
	import djkff_pkg::*;

	logic [W-1:0] prev_r;

	// ------------------------------------------------------------
	// previous pin level
	// ------------------------------------------------------------
	// reset low so a pin already high at release is seen as an edge
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			prev_r <= {W{DJKFF_PIN_RST}};
		else
			prev_r <= pin;
	end

	// edge is seen in the cycle the pin is first high
	assign rise = pin & ~prev_r;

endmodule // djkff_edge

//--- djkff_top.sv
/*
 * Dual steered flip-flop: per stage a stage clock pin, set-steer and
 * active-low reset-steer data, active-low set and clear overrides,
 * true and complement outputs, all outputs held in flip-flops.
 * Assumes every input is synchronous to clk; overrides therefore take
 * effect on the next clk edge rather than combinationally.
 */
`timescale 1ns/1ps
module djkff_top
#(
	parameter int N = djkff_pkg::DJKFF_NUM_STAGES
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [N-1:0] stage_clk,
	input wire logic [N-1:0] set_steer,
	input wire logic [N-1:0] reset_steer_n,
	input wire logic [N-1:0] async_set_n,
	input wire logic [N-1:0] async_reset_n,
	output logic [N-1:0] q,
	output logic [N-1:0] q_n
);
	import djkff_pkg::*;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------

	// next true level for a clocked update from the steering pair
	function automatic logic djkff_steer_next(input logic [1:0] pair, input logic cur);
		logic nxt;
		nxt = cur;
		case (pair)
			DJKFF_STEER_LOAD0: nxt = 1'h0;
			DJKFF_STEER_LOAD1: nxt = 1'h1;
			DJKFF_STEER_TOGGLE: nxt = ~cur;
			DJKFF_STEER_HOLD: nxt = cur;
			default: nxt = cur;
		endcase
		return nxt;
	endfunction

	// ------------------------------------------------------------
	// stage clock edges
	// ------------------------------------------------------------
	logic [N-1:0] stage_rise;

	// one shared finder; each bit belongs to its own stage
	djkff_edge #(
		.W(N)
	) u_edge (
		.clk(clk),
		.resetn(resetn),
		.pin(stage_clk),
		.rise(stage_rise)
	);

	// ------------------------------------------------------------
	// stages
	// ------------------------------------------------------------
	logic [N-1:0] q_r;
	logic [N-1:0] qn_r;
	logic [N-1:0] q_nxt;
	logic [N-1:0] qn_nxt;

	assign q = q_r;
	assign q_n = qn_r;

	genvar gi;
	generate
		// stages share nothing but the system clock and reset
		for (gi = 0; gi < N; gi++)
		begin : g_stage
			logic [1:0] pair;

			assign pair = {set_steer[gi], reset_steer_n[gi]};

			// override priority first, then the sampled steering pair
			always_comb
			begin
				q_nxt[gi] = q_r[gi];
				qn_nxt[gi] = qn_r[gi];
				if (!async_set_n[gi] && !async_reset_n[gi])
				begin
					// both overrides: both high, kept after a joint release until an edge or override
					q_nxt[gi] = 1'h1;
					qn_nxt[gi] = 1'h1;
				end
				else if (!async_set_n[gi])
				begin
					q_nxt[gi] = 1'h1;
					qn_nxt[gi] = 1'h0;
				end
				else if (!async_reset_n[gi])
				begin
					q_nxt[gi] = 1'h0;
					qn_nxt[gi] = 1'h1;
				end
				else if (stage_rise[gi])
				begin
					// pair is taken only at the edge, later changes ignored
					q_nxt[gi] = djkff_steer_next(pair, q_r[gi]);
					qn_nxt[gi] = ~djkff_steer_next(pair, q_r[gi]);
				end
			end

			// state register; without an edge or an override nothing moves
			always_ff @(posedge clk or negedge resetn)
			begin
				if (!resetn)
				begin
					q_r[gi] <= DJKFF_Q_RST;
					qn_r[gi] <= DJKFF_QN_RST;
				end
				else
				begin
					q_r[gi] <= q_nxt[gi];
					qn_r[gi] <= qn_nxt[gi];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	// outputs are flops, so every output check looks one clk after its cause
	default clocking cb @(posedge clk);
	endclocking

	default disable iff (!resetn);

	generate
		for (gi = 0; gi < N; gi++)
		begin : g_check
			logic quiet;

			// both overrides inactive
			assign quiet = async_set_n[gi] && async_reset_n[gi];

			a_set_override: assert property (
				(!async_set_n[gi] && async_reset_n[gi])
				|=> (q[gi] && !q_n[gi]))
			else $error("set override did not force true high");

			a_clear_override: assert property (
				(async_set_n[gi] && !async_reset_n[gi])
				|=> (!q[gi] && q_n[gi]))
			else $error("clear override did not force true low");

			a_both_low_high: assert property (
				(!async_set_n[gi] && !async_reset_n[gi])
				|=> (q[gi] && q_n[gi]))
			else $error("both overrides low did not give both high");

			a_both_low_release: assert property (
				(!async_set_n[gi] && !async_reset_n[gi])
				##1 (async_set_n[gi] && !async_reset_n[gi])
				|=> (!q[gi] && q_n[gi]))
			else $error("both-high state persisted after set released");

			a_edge_sample: assert property (
				(quiet && stage_clk[gi] && !$past(stage_clk[gi])
				&& set_steer[gi] && reset_steer_n[gi])
				|=> (q[gi] && !q_n[gi]))
			else $error("stage clock rise did not load high");

			a_steer_ignored: assert property (
				(quiet && !(stage_clk[gi] && !$past(stage_clk[gi])))
				|=> ($stable(q[gi]) && $stable(q_n[gi])))
			else $error("outputs moved without a stage clock rise");

			a_toggle_stage: assert property (
				(quiet && stage_rise[gi] && set_steer[gi] && !reset_steer_n[gi])
				|=> (q[gi] == !$past(q[gi])) && (q_n[gi] == !q[gi]))
			else $error("toggle pair did not invert the state");

			a_dtype_load: assert property (
				(quiet && stage_rise[gi] && (set_steer[gi] == reset_steer_n[gi]))
				|=> (q[gi] == $past(set_steer[gi])) && (q_n[gi] != q[gi]))
			else $error("equal steering levels were not loaded");

			a_hold_pair: assert property (
				(quiet && stage_rise[gi] && !set_steer[gi] && reset_steer_n[gi])
				|=> (q[gi] == $past(q[gi])))
			else $error("hold pair changed the state");

			a_load_low: assert property (
				(quiet && stage_rise[gi] && !set_steer[gi] && !reset_steer_n[gi])
				|=> (!q[gi] && q_n[gi]))
			else $error("low steering pair did not load low");

			a_rise_seen: assert property (
				(stage_clk[gi] && !$past(stage_clk[gi]))
				|-> stage_rise[gi])
			else $error("stage clock rise was missed by the edge finder");

			// only both overrides low may break the complement pair
			a_pair_complement: assert property (
				((q[gi] != q_n[gi]) && (async_set_n[gi] || async_reset_n[gi]))
				|=> (q[gi] != q_n[gi]))
			else $error("outputs lost their complement pair");

			c_toggle_twice: cover property (
				(quiet && stage_rise[gi] && set_steer[gi] && !reset_steer_n[gi])
				##2 (quiet && stage_rise[gi] && set_steer[gi] && !reset_steer_n[gi]));

			c_load_high: cover property (
				quiet && stage_rise[gi] && set_steer[gi] && reset_steer_n[gi]);

			c_both_low: cover property (
				!async_set_n[gi] && !async_reset_n[gi]);

			c_set_then_clear: cover property (
				!async_set_n[gi] ##1 (async_set_n[gi] && !async_reset_n[gi]));

			c_release_together: cover property (
				(!async_set_n[gi] && !async_reset_n[gi]) ##1 quiet);
		end
	endgenerate

endmodule // djkff_top

//--- djkff_src.sv
/*
 * Partner model: the surrounding logic that feeds the steered flip-flops.
 * Assumes the bench calls put once per clk cycle, from a single process.
 */
`timescale 1ns/1ps
module djkff_src
#(
	parameter int N = 2
)
(
	input wire logic clk,
	output logic [N-1:0] stage_clk,
	output logic [N-1:0] set_steer,
	output logic [N-1:0] reset_steer_n,
	output logic [N-1:0] async_set_n,
	output logic [N-1:0] async_reset_n
);
	// idle levels: overrides released, stage clocks low
	initial
	begin
		stage_clk = '0;
		set_steer = '0;
		reset_steer_n = '0;
		async_set_n = '1;
		async_reset_n = '1;
	end

	// launch just after the edge so no sample ever races the change
	task automatic put(input logic [N-1:0] c, j, k, s, r);
		@(posedge clk);
		#1;
		stage_clk = c;
		set_steer = j;
		reset_steer_n = k;
		async_set_n = s;
		async_reset_n = r;
	endtask
endmodule // djkff_src

//--- djkff_top_tb.sv
/*
 * Self-checking bench for the dual steered flip-flop block.
 * Assumes outputs move on the clk edge that samples their cause.
 */
`timescale 1ns/1ps
module djkff_top_tb;
	import djkff_pkg::*;
	localparam int N = DJKFF_NUM_STAGES;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	wire logic [N-1:0] sc, js, ks, ps, cs, q, q_n;
	int bad_count = 0;
	int num_checks = 0;
	int seed = 32'hAF93;
	logic [2*N-1:0] exp_q[$];
	logic [2*N-1:0] pend_v;
	logic pend = 1'b0;
	logic [N-1:0] mq = '0, mqn = '1, mprev = '0;

	always #12.5 clk = ~clk;

	djkff_src #(.N(N)) SRC (.clk(clk), .stage_clk(sc), .set_steer(js), .reset_steer_n(ks),
		.async_set_n(ps), .async_reset_n(cs));
	djkff_top #(.N(N)) DUT (.clk(clk), .resetn(resetn), .stage_clk(sc), .set_steer(js),
		.reset_steer_n(ks), .async_set_n(ps), .async_reset_n(cs), .q(q), .q_n(q_n));

	// drive one cycle and note what the outputs must show one clk later
	task automatic cyc(input logic [N-1:0] c, j, k, s, r);
		int i;
		SRC.put(c, j, k, s, r);
		if (pend)
			exp_q.push_back(pend_v);
		for (i = 0; i < N; i++)
		begin
			if (!s[i] && !r[i])
				{mq[i], mqn[i]} = 2'h3;
			else if (!s[i])
				{mq[i], mqn[i]} = 2'h2;
			else if (!r[i])
				{mq[i], mqn[i]} = 2'h1;
			else if (c[i] && !mprev[i])
			begin
				case ({j[i], k[i]})
					DJKFF_STEER_LOAD0: mq[i] = 1'h0;
					DJKFF_STEER_LOAD1: mq[i] = 1'h1;
					DJKFF_STEER_TOGGLE: mq[i] = ~mq[i];
					default: ;
				endcase
				mqn[i] = ~mq[i];
			end
		end
		mprev = c;
		pend_v = {mq, mqn};
		pend = 1'b1;
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// monitor: outputs are settled mid-cycle, take the oldest note
	always @(negedge clk)
	begin
		if (exp_q.size() > 0)
		begin
			num_checks++;
			if ({q, q_n} !== exp_q[0])
			begin
				bad_count++;
				$display("ERROR q_q_n expected %h seen %h", exp_q[0], {q, q_n});
			end
			void'(exp_q.pop_front());
		end
	end

	// watchdog: the whole run needs about 230 clk
	initial
	begin
		#(3000 * 25);
		bad_count++;
		$display("ERROR watchdog expected end seen hang");
		complete_run();
	end

	initial
	begin
		repeat (2) @(posedge clk);
		#1 resetn = 1'b1;
		cyc(2'h0, 2'h0, 2'h0, 2'h3, 2'h3);
		for (int p = 0; p < 4; p++)
		begin
			cyc(2'h0, 2'h0, 2'h0, 2'h3, 2'h3);
			cyc(2'h3, {2{p[1]}}, {2{p[0]}}, 2'h3, 2'h3);
			cyc(2'h3, ~{2{p[1]}}, ~{2{p[0]}}, 2'h3, 2'h3);
		end
		repeat (2)
		begin
			cyc(2'h0, 2'h1, 2'h2, 2'h3, 2'h3);
			cyc(2'h3, 2'h1, 2'h2, 2'h3, 2'h3);
		end
		cyc(2'h3, 2'h3, 2'h3, 2'h3, 2'h3);
		cyc(2'h0, 2'h3, 2'h0, 2'h2, 2'h1);
		cyc(2'h3, 2'h3, 2'h0, 2'h1, 2'h2);
		cyc(2'h0, 2'h0, 2'h0, 2'h0, 2'h0);
		cyc(2'h0, 2'h0, 2'h0, 2'h3, 2'h0);
		cyc(2'h0, 2'h0, 2'h0, 2'h0, 2'h0);
		cyc(2'h0, 2'h0, 2'h0, 2'h3, 2'h3);
		cyc(2'h3, 2'h0, 2'h3, 2'h3, 2'h3);
		repeat (200)
			cyc(N'($random(seed)), N'($random(seed)), N'($random(seed)),
				N'($random(seed) | $random(seed)), N'($random(seed) | $random(seed)));
		cyc(2'h0, 2'h0, 2'h0, 2'h3, 2'h3);
		cyc(2'h0, 2'h0, 2'h0, 2'h3, 2'h3);
		// let the monitor take the last note before the verdict
		@(negedge clk);
		#1;
		complete_run();
	end
endmodule // djkff_top_tb
